// File: rtl/ccr_page_regs.sv
/*
 Register page for equalizer boost, clock-recovery status and
 output mux override. Reached through the management port once
 the page-select field outside equals the page code.
 Assumes the mode, mux-select and adaptive boost values come from
 logic on the same clock; loss and status come from analog blocks.
*/
// Notes on behaviour
// - Page reset bit restores defaults, self-clears
// - Bit 1 at 0x01 shows second input loss
// - Offset 0x02 is status byte, default 0x41
// - Manual boost applies only in manual mode
// - Boost byte splits into four 2-bit stages
// - Applied boost is driven out on applied_boost_o only; it has no read offset
// - Common select drives both outputs when clear
// - Per-output selects when override bit set
module ccr_page_regs (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Management port
   input wire logic [2:0] page_select_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic rd_valid_o,
   // Status from analog blocks
   input wire logic second_input_signal_lost_i,
   input wire logic [7:0] recovery_status_i,
   // Related registers held elsewhere
   input wire logic [7:0] eq_mode_reg_i,
   input wire logic [7:0] first_output_mux_reg_i,
   input wire logic [7:0] second_output_mux_reg_i,
   input wire logic [7:0] adaptive_boost_i,
   // Equalizer controls
   output logic [1:0] stage0_boost_o,
   output logic [1:0] stage1_boost_o,
   output logic [1:0] stage2_boost_o,
   output logic [1:0] stage3_boost_o,
   output logic [7:0] applied_boost_o,
   // Output mux controls and page reset pulse
   output logic [2:0] first_output_sel_o,
   output logic [2:0] second_output_sel_o,
   output logic page_reset_pulse_o
);
   import ccr_pkg::*;

   // ==========================================================
   // Access decode
   logic page_hit;
   logic wr_hit;
   logic page_reset_trigger;
   logic [7:0] manual_boost_reg;
   logic [7:0] select_override_reg;
   logic [7:0] loss_status_reg;
   logic [7:0] recovery_status_reg;
   logic second_input_signal_lost;
   logic [7:0] recovery_status_sync;
   logic [7:0] boost_next;
   logic [7:0] rdata_next;
   logic manual_mode;
   logic per_output_select_enable;

   // Accesses from other pages never touch this one
   assign page_hit = (page_select_i == CCR_PAGE_CODE);
   assign wr_hit = wr_en_i && page_hit;
   assign page_reset_trigger = wr_hit && (addr_i == CCR_OFS_SOFT_RESET) &&
      wdata_i[CCR_BIT_PAGE_RESET];

   // ==========================================================
   // Status inputs cross from the analog side
   // Syncs start at the register defaults, so a read just after reset
   // shows those defaults rather than a false zero from the flops
   ccr_sync #(
      .WIDTH(1)
   ) u_loss_sync (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .async_i(second_input_signal_lost_i),
      .reset_value_i(1'b1),
      .sync_o(second_input_signal_lost)
   );

   ccr_sync #(
      .WIDTH(8)
   ) u_status_sync (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .async_i(recovery_status_i),
      .reset_value_i(CCR_RST_RECOVERY_STATUS),
      .sync_o(recovery_status_sync)
   );

   // ==========================================================
   // Page reset pulse
   // Bit is never stored, so it always reads back zero
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         page_reset_pulse_o <= 1'b0;
      end else begin
         page_reset_pulse_o <= page_reset_trigger;
      end
   end

   // ==========================================================
   // Writable registers
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || page_reset_trigger) begin
         manual_boost_reg <= CCR_RST_MANUAL_BOOST;
      end else if (wr_hit && addr_i == CCR_OFS_MANUAL_BOOST) begin
         manual_boost_reg <= wdata_i;
      end
   end

   // Only the override bit is stored; reserved bits stay at default
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || page_reset_trigger) begin
         select_override_reg <= CCR_RST_SELECT_OVERRIDE;
      end else if (wr_hit && addr_i == CCR_OFS_SELECT_OVERRIDE) begin
         select_override_reg[CCR_BIT_PER_OUTPUT] <= wdata_i[CCR_BIT_PER_OUTPUT];
      end
   end

   // ==========================================================
   // Status registers
   // Held at their defaults for the reset cycle, then track inputs
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || page_reset_trigger) begin
         loss_status_reg <= CCR_RST_LOSS_STATUS;
      end else begin
         loss_status_reg[CCR_BIT_SIGNAL_LOST] <= second_input_signal_lost;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i || page_reset_trigger) begin
         recovery_status_reg <= CCR_RST_RECOVERY_STATUS;
      end else begin
         recovery_status_reg <= recovery_status_sync;
      end
   end

   // ==========================================================
   // Equalizer boost
   assign manual_mode = eq_mode_reg_i[CCR_BIT_MANUAL_MODE];
   assign boost_next = manual_mode ? manual_boost_reg : adaptive_boost_i;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         applied_boost_o <= CCR_RST_MANUAL_BOOST;
         stage0_boost_o <= CCR_RST_MANUAL_BOOST[7:6];
         stage1_boost_o <= CCR_RST_MANUAL_BOOST[5:4];
         stage2_boost_o <= CCR_RST_MANUAL_BOOST[3:2];
         stage3_boost_o <= CCR_RST_MANUAL_BOOST[1:0];
      end else begin
         applied_boost_o <= boost_next;
         stage0_boost_o <= boost_next[7:6];
         stage1_boost_o <= boost_next[5:4];
         stage2_boost_o <= boost_next[3:2];
         stage3_boost_o <= boost_next[1:0];
      end
   end

   // ==========================================================
   // Output mux selection
   assign per_output_select_enable = select_override_reg[CCR_BIT_PER_OUTPUT];

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         first_output_sel_o <= 3'h0;
         second_output_sel_o <= 3'h0;
      end else if (per_output_select_enable) begin
         first_output_sel_o <=
            first_output_mux_reg_i[CCR_OUTPUT_SEL_HI:CCR_OUTPUT_SEL_LO];
         second_output_sel_o <=
            second_output_mux_reg_i[CCR_OUTPUT_SEL_HI:CCR_OUTPUT_SEL_LO];
      end else begin
         first_output_sel_o <=
            {1'b0, first_output_mux_reg_i[CCR_COMMON_SEL_HI:CCR_COMMON_SEL_LO]};
         second_output_sel_o <=
            {1'b0, first_output_mux_reg_i[CCR_COMMON_SEL_HI:CCR_COMMON_SEL_LO]};
      end
   end

   // ==========================================================
   // Read path
   // Reserved and unmapped offsets read zero
   always_comb begin
      rdata_next = 8'h00;
      if (addr_i == CCR_OFS_SOFT_RESET) begin
         rdata_next = CCR_RST_SOFT_RESET;
      end else if (addr_i == CCR_OFS_LOSS_STATUS) begin
         rdata_next = loss_status_reg;
      end else if (addr_i == CCR_OFS_RECOVERY_STATUS) begin
         rdata_next = recovery_status_reg;
      end else if (addr_i == CCR_OFS_MANUAL_BOOST) begin
         rdata_next = manual_boost_reg;
      end else if (addr_i >= CCR_OFS_RSVD_FIRST && addr_i <= CCR_OFS_RSVD_LAST) begin
         rdata_next = CCR_RST_RESERVED;
      end else if (addr_i == CCR_OFS_SELECT_OVERRIDE) begin
         rdata_next = select_override_reg;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= rd_en_i && page_hit;
         if (rd_en_i && page_hit) begin
            rdata_o <= rdata_next;
         end
      end
   end
endmodule

// File: rtl/ccr_pkg.sv
/*
 Constants for the equalizer and clock-recovery control page:
 page code, register offsets, field positions and reset values.
 Assumes an 8-bit register address and 8-bit data path.
*/
package ccr_pkg;
   // ==========================================================
   // Page selection
   localparam logic [2:0] CCR_PAGE_CODE = 3'h4;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] CCR_OFS_SOFT_RESET = 8'h00;
   localparam logic [7:0] CCR_OFS_LOSS_STATUS = 8'h01;
   localparam logic [7:0] CCR_OFS_RECOVERY_STATUS = 8'h02;
   localparam logic [7:0] CCR_OFS_MANUAL_BOOST = 8'h03;
   localparam logic [7:0] CCR_OFS_RSVD_FIRST = 8'h04;
   localparam logic [7:0] CCR_OFS_RSVD_LAST = 8'h08;
   localparam logic [7:0] CCR_OFS_SELECT_OVERRIDE = 8'h09;

   // ==========================================================
   // Field positions
   localparam int CCR_BIT_PAGE_RESET = 2;
   localparam int CCR_BIT_SIGNAL_LOST = 1;
   localparam int CCR_BIT_PER_OUTPUT = 5;
   localparam int CCR_BIT_MANUAL_MODE = 3;
   localparam int CCR_COMMON_SEL_HI = 3;
   localparam int CCR_COMMON_SEL_LO = 2;
   localparam int CCR_OUTPUT_SEL_HI = 7;
   localparam int CCR_OUTPUT_SEL_LO = 5;

   // ==========================================================
   // Reset values
   localparam logic [7:0] CCR_RST_SOFT_RESET = 8'h00;
   localparam logic [7:0] CCR_RST_LOSS_STATUS = 8'h03;
   localparam logic [7:0] CCR_RST_RECOVERY_STATUS = 8'h41;
   localparam logic [7:0] CCR_RST_MANUAL_BOOST = 8'h80;
   localparam logic [7:0] CCR_RST_RESERVED = 8'h00;
   localparam logic [7:0] CCR_RST_SELECT_OVERRIDE = 8'h00;
endpackage

// File: rtl/ccr_sync.sv
/*
 Two-stage synchroniser for a bus of level signals.
 Assumes each bit is a slowly changing level; multi-bit words may
 show a mixed value for one cycle while they change.
*/
module ccr_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Data
   input wire logic [WIDTH-1:0] async_i,
   input wire logic [WIDTH-1:0] reset_value_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1_reg;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         stage1_reg <= reset_value_i;
         sync_o <= reset_value_i;
      end else begin
         stage1_reg <= async_i;
         sync_o <= stage1_reg;
      end
   end
endmodule

// File: verification/ccr_page_regs_sva.sv
/*
 Checker for the equalizer and clock-recovery control page.
 Assumes it is bound to ccr_page_regs and sees only its ports.
*/
module ccr_page_regs_sva
   import ccr_pkg::*;
(
   // Clock, reset and single-bit ports
   input wire logic clock_i, rst_n_i, wr_en_i, rd_en_i, rd_valid_o, page_reset_pulse_o,
   // Byte ports
   input wire logic [7:0] addr_i, wdata_i, rdata_o, eq_mode_reg_i, adaptive_boost_i,
   input wire logic [7:0] first_output_mux_reg_i, second_output_mux_reg_i, applied_boost_o,
   // Selects and stages
   input wire logic [2:0] page_select_i, first_output_sel_o, second_output_sel_o,
   input wire logic [1:0] stage0_boost_o, stage1_boost_o, stage2_boost_o, stage3_boost_o
);
   // ==========================================================
   // Shadow of the two writable controls, to judge the outputs
   logic sel, wr, prst, ovr_reg;
   logic [7:0] man_reg;
   assign sel = page_select_i == CCR_PAGE_CODE;
   assign wr = wr_en_i && sel;
   assign prst = wr && addr_i == CCR_OFS_SOFT_RESET && wdata_i[2];
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || prst) ovr_reg <= 1'b0;
      else if (wr && addr_i == CCR_OFS_SELECT_OVERRIDE) ovr_reg <= wdata_i[5];
   end
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || prst) man_reg <= CCR_RST_MANUAL_BOOST;
      else if (wr && addr_i == CCR_OFS_MANUAL_BOOST) man_reg <= wdata_i;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================================
   // Assertions
   // Antecedents need reset high in the sampled value: the release edge
   // still resets the outputs, so it must not start an attempt
   a_reset_pulse_once: assert property (rst_n_i |=> page_reset_pulse_o == $past(prst))
      else $error("page reset pulse wrong");
   a_trigger_reads_zero: assert property (rst_n_i && rd_en_i && sel &&
      addr_i == 8'h00 |=> rdata_o == 8'h00) else $error("reset trigger did not read zero");
   a_manual_boost: assert property (rst_n_i && eq_mode_reg_i[3] |=>
      applied_boost_o == $past(man_reg)) else $error("manual boost not applied");
   a_adaptive_boost: assert property (rst_n_i && !eq_mode_reg_i[3] |=>
      applied_boost_o == $past(adaptive_boost_i)) else $error("adaptive boost not applied");
   a_stage_split: assert property (rst_n_i |=>
      {stage0_boost_o, stage1_boost_o, stage2_boost_o, stage3_boost_o} ==
      ($past(eq_mode_reg_i[3]) ? $past(man_reg) : $past(adaptive_boost_i)))
      else $error("stage split wrong");
   a_common_select: assert property (rst_n_i && !ovr_reg |=>
      first_output_sel_o == {1'b0, $past(first_output_mux_reg_i[3:2])} &&
      second_output_sel_o == first_output_sel_o) else $error("common select wrong");
   a_own_select: assert property (rst_n_i && ovr_reg |=>
      first_output_sel_o == $past(first_output_mux_reg_i[7:5]) &&
      second_output_sel_o == $past(second_output_mux_reg_i[7:5])) else $error("own select wrong");
   a_read_answer: assert property (rst_n_i && rd_en_i && sel |=> rd_valid_o)
      else $error("read not answered");
   a_read_refused: assert property (rd_en_i && !sel |=> !rd_valid_o)
      else $error("off-page read answered");
   a_reserved_zero: assert property (rd_en_i && sel && (addr_i inside {[8'h04:8'h08]} ||
      addr_i > 8'h09) |=> rdata_o == 8'h00) else $error("reserved read not zero");
endmodule

bind ccr_page_regs ccr_page_regs_sva u_sva (.*);

// File: verification/ccr_page_regs_tb_top.sv
/*
 Self-checking bench for the control page: table of write/read rows,
 then outputs, page reset and off-page access.
 Assumes the register port contract of ccr_page_regs.
*/
module ccr_page_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ccr_pkg::*;
   logic clock_i = 0, rst_n_i = 0, wr_en_i = 0, rd_en_i = 0, second_input_signal_lost_i = 1;
   logic [2:0] page_select_i = 3'h4;
   logic [7:0] addr_i = 0, wdata_i = 0, recovery_status_i = 8'h5c, eq_mode_reg_i = 8'h08;
   logic [7:0] first_output_mux_reg_i = 8'ha4, second_output_mux_reg_i = 8'h60;
   logic [7:0] adaptive_boost_i = 8'hc3, rdata_o, applied_boost_o;
   logic rd_valid_o, page_reset_pulse_o;
   logic [1:0] stage0_boost_o, stage1_boost_o, stage2_boost_o, stage3_boost_o;
   logic [2:0] first_output_sel_o, second_output_sel_o;
   int n_fail = 0, compares = 0;
   // Rows: offset, write data, expected read
   logic [23:0] rows [6] = '{24'h035a5a, 24'h09ff20, 24'h05ff00, 24'h0cff00, 24'h000300,
      24'h02ff5c};
   ccr_page_regs u_dut (.clock_i, .rst_n_i, .page_select_i, .wr_en_i, .rd_en_i, .addr_i,
      .wdata_i, .rdata_o, .rd_valid_o, .second_input_signal_lost_i, .recovery_status_i,
      .eq_mode_reg_i, .first_output_mux_reg_i, .second_output_mux_reg_i, .adaptive_boost_i,
      .stage0_boost_o, .stage1_boost_o, .stage2_boost_o, .stage3_boost_o, .applied_boost_o,
      .first_output_sel_o, .second_output_sel_o, .page_reset_pulse_o);
   initial forever #2 clock_i = ~clock_i;
   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      wr_en_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clock_i);
      wr_en_i <= 1'b0;
   endtask
   // Off-page reads expect no answer, so data is only judged when valid is expected
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic v = 1'b1);
      @(posedge clock_i);
      rd_en_i <= 1'b1;
      addr_i <= a;
      @(posedge clock_i);
      rd_en_i <= 1'b0;
      #1;
      chk("rd_valid_o", {7'h0, v}, {7'h0, rd_valid_o});
      if (v) chk("rdata_o", e, rdata_o);
   endtask
   task automatic conclude;
      if (n_fail == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // Sequence
   initial begin
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      #1;
      chk("applied_boost_o", 8'h80, applied_boost_o);
      rd(8'h09, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      rd(8'h01, 8'h03);
      chk("stages", 8'h5a, {stage0_boost_o, stage1_boost_o, stage2_boost_o, stage3_boost_o});
      chk("applied_boost_o", 8'h5a, applied_boost_o);
      chk("first_output_sel_o", 8'h05, {5'h0, first_output_sel_o});
      chk("second_output_sel_o", 8'h03, {5'h0, second_output_sel_o});
      @(posedge clock_i);
      second_input_signal_lost_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      rd(8'h01, 8'h01);
      wr(8'h00, 8'h04);
      #1;
      chk("page_reset_pulse_o", 8'h01, {7'h0, page_reset_pulse_o});
      rd(8'h03, 8'h80);
      rd(8'h09, 8'h00);
      chk("first_output_sel_o", 8'h01, {5'h0, first_output_sel_o});
      chk("second_output_sel_o", 8'h01, {5'h0, second_output_sel_o});
      chk("applied_boost_o", 8'h80, applied_boost_o);
      wr(8'h09, 8'h00);
      eq_mode_reg_i <= 8'h00;
      repeat (2) @(posedge clock_i);
      #1;
      chk("applied_boost_o", 8'hc3, applied_boost_o);
      @(posedge clock_i);
      page_select_i <= 3'h0;
      wr(8'h03, 8'hff);
      rd(8'h03, 8'h00, 1'b0);
      @(posedge clock_i);
      page_select_i <= 3'h4;
      rd(8'h03, 8'h80);
      // Mid-run hard reset: a written boost must fall back to its default
      wr(8'h03, 8'h3c);
      @(posedge clock_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      chk("applied_boost_o", 8'h80, applied_boost_o);
      chk("first_output_sel_o", 8'h00, {5'h0, first_output_sel_o});
      @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd(8'h02, 8'h41);
      rd(8'h03, 8'h80);
      conclude;
   end
   // Whole run is about 70 cycles; over twenty times that marks a hang
   initial begin
      repeat (1500) @(posedge clock_i);
      n_fail++;
      conclude;
   end
endmodule
